// >>> rtl/pvt_map.svh
// register offsets, field positions, reset values and video timing counts
// assumes inclusion by the receiver top only
`ifndef PVT_MAP_SVH
`define PVT_MAP_SVH

// register byte offsets
`define PVT_OFF_CTRL        8'h00
`define PVT_OFF_STATUS      8'h04
`define PVT_OFF_LINE_ACT    8'h08
`define PVT_OFF_LINE_BLANK  8'h0c
`define PVT_OFF_FRAME_LINES 8'h10
`define PVT_OFF_FRAME_CNT   8'h14

// control fields
`define PVT_CTRL_EN         0
`define PVT_CTRL_USE_REG    1
`define PVT_CTRL_DEPTH10    2
`define PVT_CTRL_RST        3'h1

// status fields
`define PVT_ST_ERR_ACT      0
`define PVT_ST_ERR_BLANK    1
`define PVT_ST_ERR_LINES    2
`define PVT_ST_OVF          3
`define PVT_ST_DEPTH10      4
`define PVT_ST_IN_FRAME     5

// video timing in pixel clocks and lines
`define PVT_ACTIVE_PIX      12'd480
`define PVT_HBLANK_MIN      12'd60
`define PVT_HBLANK_MAX      12'd120
`define PVT_VBLANK_GAP      12'd600
`define PVT_ACTIVE_LINES    12'd2160

`endif

// >>> rtl/pvt_pkg.sv
// types shared by the panel video receiver
// assumes the map header sits beside it
package pvt_pkg;
  typedef enum logic [1:0] {ST_VBLANK, ST_ACTIVE, ST_HBLANK} pvt_state_type;
  typedef logic [11:0] pvt_count_type;
endpackage

// >>> rtl/pvt_fifo.sv
// small synchronous fifo with valid/ready on both sides
// assumes one clock and a synchronous active-high reset
`timescale 1ns/100ps
module pvt_fifo #(
  parameter int WIDTH = 35,
  parameter int DEPTH = 4
) (
  // clock and reset
  input  wire logic             clock,
  input  wire logic             srst,
  // fill side
  input  wire logic             in_valid,
  output logic                  in_ready,
  input  wire logic [WIDTH-1:0] in_data,
  // drain side
  output logic                  out_valid,
  input  wire logic             out_ready,
  output logic      [WIDTH-1:0] out_data
);
  localparam int AW = $clog2(DEPTH);

  logic [WIDTH-1:0] mem_ff [DEPTH];
  logic [AW-1:0]    wr_ptr_ff;
  logic [AW-1:0]    rd_ptr_ff;
  logic [AW:0]      cnt_ff;
  wire              push = in_valid && in_ready;
  wire              pop  = out_valid && out_ready;

  // room is judged on the count alone, so an empty fifo always accepts
  assign in_ready  = (cnt_ff < (AW+1)'(DEPTH));
  assign out_valid = (cnt_ff != '0);
  assign out_data  = mem_ff[rd_ptr_ff];

  always_ff @(posedge clock) begin
    if (push) begin
      mem_ff[wr_ptr_ff] <= in_data;
    end
  end

  // pointers wrap by depth so non power-of-two depths still work
  always_ff @(posedge clock) begin
    if (srst) begin
      wr_ptr_ff <= '0;
      rd_ptr_ff <= '0;
      cnt_ff    <= '0;
    end else begin
      if (push) begin
        wr_ptr_ff <= (wr_ptr_ff == AW'(DEPTH-1)) ? '0 : wr_ptr_ff + 1'b1;
      end
      if (pop) begin
        rd_ptr_ff <= (rd_ptr_ff == AW'(DEPTH-1)) ? '0 : rd_ptr_ff + 1'b1;
      end
      cnt_ff <= cnt_ff + (AW+1)'(push) - (AW+1)'(pop);
    end
  end
endmodule // pvt_fifo

// >>> rtl/pvt_panel_rx.sv
// panel video receiver: unpacks 32-bit packer words, times lines and frames
// assumes words arrive lane-aligned on one clock, registers over ahb-lite
//
// The register offsets and register access over AHB-Lite were decided locally.
`timescale 1ns/100ps
`include "pvt_map.svh"
module pvt_panel_rx #(
  parameter int FIFO_DEPTH = 4
) (
  // clock and reset
  input  wire logic                  clock,
  input  wire logic                  srst,
  // video input
  input  wire logic                  pixel_valid_window,
  input  wire logic [31:0]           pix_data,
  input  wire logic                  hsync,
  input  wire logic                  vsync,
  input  wire logic                  depth_sel_pin,
  output logic                       pix_ready,
  // unpacked pixel stream
  output logic                       out_valid,
  input  wire logic                  out_ready,
  output logic [9:0]                 out_red,
  output logic [9:0]                 out_green,
  output logic [9:0]                 out_blue,
  output logic [2:0]                 out_lane,
  output logic                       out_sol,
  output logic                       out_sof,
  // ahb-lite slave
  input  wire logic                  hsel,
  input  wire logic [7:0]            haddr,
  input  wire logic [1:0]            htrans,
  input  wire logic                  hwrite,
  input  wire logic [2:0]            hsize,
  input  wire logic [31:0]           hwdata,
  input  wire logic                  hready,
  output logic [31:0]                hrdata,
  output logic                       hreadyout,
  output logic                       hresp
);
  import pvt_pkg::*;

  pvt_state_type    state_ff, nxt_state;
  logic             pv_d_ff;
  pvt_count_type    act_cnt_ff, gap_cnt_ff, line_cnt_ff;
  pvt_count_type    meas_act_ff, meas_blank_ff, meas_lines_ff;
  logic [15:0]      frame_cnt_ff;
  logic [2:0]       ctrl_ff;
  logic [3:0]       err_ff;
  logic [7:0]       addr_ff;
  logic             wr_ff;
  logic [31:0]      hrdata_ff;
  logic [34:0]      fifo_out;

  // unused by design: sync pins never steer timing
  wire sync_unused = hsync ^ vsync;

  // framing from the valid window alone
  wire rise      = pixel_valid_window && !pv_d_ff;
  wire line_end  = !pixel_valid_window && pv_d_ff;
  wire frame_end = (state_ff == ST_HBLANK) && (gap_cnt_ff == `PVT_VBLANK_GAP);
  wire sof       = rise && (state_ff == ST_VBLANK);

  always_comb begin
    nxt_state = state_ff;
    unique case (state_ff)
      ST_VBLANK: if (rise) nxt_state = ST_ACTIVE;
      ST_ACTIVE: if (line_end) nxt_state = ST_HBLANK;
      ST_HBLANK: begin
        if (rise) nxt_state = ST_ACTIVE;
        else if (frame_end) nxt_state = ST_VBLANK;
      end
      // the fourth code of the state vector is unused; recover to vblank
      default: nxt_state = ST_VBLANK;
    endcase
  end

  // depth pin, open pin reads high outside; register may override
  wire depth10 = ctrl_ff[`PVT_CTRL_USE_REG] ? ctrl_ff[`PVT_CTRL_DEPTH10] : depth_sel_pin;

  // 30-bit word: msbs in bytes 0..2, lsb pairs in byte3, 25:24 dropped
  wire [9:0] red10   = {pix_data[7:0],   pix_data[31:30]};
  wire [9:0] green10 = {pix_data[15:8],  pix_data[29:28]};
  wire [9:0] blue10  = {pix_data[23:16], pix_data[27:26]};
  // 24-bit word: top byte ignored; msb replication keeps full-scale white
  // replication is monotonic, so brighter codes stay brighter
  wire [9:0] red8    = {pix_data[7:0],   pix_data[7:6]};
  wire [9:0] green8  = {pix_data[15:8],  pix_data[15:14]};
  wire [9:0] blue8   = {pix_data[23:16], pix_data[23:22]};
  // either depth accepted per configuration
  wire [29:0] rgb    = depth10 ? {red10, green10, blue10} : {red8, green8, blue8};

  // lane skew is removed by the deserialiser ahead of this word
  // lane of pixel n is n modulo 8 across eight lanes
  wire [2:0] lane    = act_cnt_ff[2:0];
  wire       pix_take = pixel_valid_window && ctrl_ff[`PVT_CTRL_EN];
  wire       ovf_set  = pix_take && !pix_ready;

  pvt_fifo #(.WIDTH(35), .DEPTH(FIFO_DEPTH)) u_fifo (
    .clock     (clock),
    .srst      (srst),
    .in_valid  (pix_take),
    .in_ready  (pix_ready),
    .in_data   ({sof, rise, lane, rgb}),
    .out_valid (out_valid),
    .out_ready (out_ready),
    .out_data  (fifo_out)
  );
  assign {out_sof, out_sol, out_lane, out_red, out_green, out_blue} = fifo_out;

  // timing checks against the nominal raster
  wire act_bad   = line_end && (act_cnt_ff != `PVT_ACTIVE_PIX);
  wire blank_bad = rise && (state_ff == ST_HBLANK) &&
                   ((gap_cnt_ff < `PVT_HBLANK_MIN) || (gap_cnt_ff > `PVT_HBLANK_MAX));
  wire lines_bad = frame_end && (line_cnt_ff != `PVT_ACTIVE_LINES);

  // ahb-lite decode; reads are fetched in the address phase, so zero wait
  wire        acc      = hsel && htrans[1] && hready;
  wire        wr_ctrl  = wr_ff && (addr_ff == `PVT_OFF_CTRL);
  wire        wr_stat  = wr_ff && (addr_ff == `PVT_OFF_STATUS);
  wire [3:0]  err_clr  = wr_stat ? hwdata[3:0] : 4'h0;
  wire [3:0]  err_set  = {ovf_set, lines_bad, blank_bad, act_bad};
  wire [31:0] status   = {26'h0, (state_ff != ST_VBLANK), depth10, err_ff};
  wire [31:0] rd_mux   =
      (haddr == `PVT_OFF_CTRL)        ? {29'h0, ctrl_ff} :
      (haddr == `PVT_OFF_STATUS)      ? status :
      (haddr == `PVT_OFF_LINE_ACT)    ? {20'h0, meas_act_ff} :
      (haddr == `PVT_OFF_LINE_BLANK)  ? {20'h0, meas_blank_ff} :
      (haddr == `PVT_OFF_FRAME_LINES) ? {20'h0, meas_lines_ff} :
      (haddr == `PVT_OFF_FRAME_CNT)   ? {16'h0, frame_cnt_ff} : 32'h0;
  wire        size_unused = |hsize;

  assign hrdata    = hrdata_ff;
  assign hreadyout = 1'b1;
  assign hresp     = 1'b0;

  always_ff @(posedge clock) begin
    if (srst) begin
      addr_ff   <= 8'h00;
      wr_ff     <= 1'b0;
      hrdata_ff <= 32'h0;
    end else begin
      addr_ff   <= haddr;
      wr_ff     <= acc && hwrite;
      if (acc && !hwrite) hrdata_ff <= rd_mux;
    end
  end

  always_ff @(posedge clock) begin
    if (srst) begin
      ctrl_ff <= `PVT_CTRL_RST;
      err_ff  <= 4'h0;
    end else begin
      if (wr_ctrl) ctrl_ff <= hwdata[2:0];
      err_ff <= err_set | (err_ff & ~err_clr); // set beats clear
    end
  end

  // the gap counter saturates at the vblank gap so long idles cannot wrap
  always_ff @(posedge clock) begin
    if (srst) begin
      state_ff   <= ST_VBLANK;
      pv_d_ff    <= 1'b0;
      act_cnt_ff <= 12'h0;
      gap_cnt_ff <= 12'h0;
    end else begin
      state_ff   <= nxt_state;
      pv_d_ff    <= pixel_valid_window;
      act_cnt_ff <= pixel_valid_window ? act_cnt_ff + 12'h1 : 12'h0;
      gap_cnt_ff <= pixel_valid_window ? 12'h0 :
                    (gap_cnt_ff == `PVT_VBLANK_GAP) ? gap_cnt_ff : gap_cnt_ff + 12'h1;
    end
  end

  always_ff @(posedge clock) begin
    if (srst) begin
      line_cnt_ff   <= 12'h0;
      meas_act_ff   <= 12'h0;
      meas_blank_ff <= 12'h0;
      meas_lines_ff <= 12'h0;
      frame_cnt_ff  <= 16'h0;
    end else begin
      if (line_end) meas_act_ff <= act_cnt_ff;
      if (rise && state_ff == ST_HBLANK) meas_blank_ff <= gap_cnt_ff;
      if (frame_end) begin
        meas_lines_ff <= line_cnt_ff;
        line_cnt_ff   <= 12'h0;
        frame_cnt_ff  <= frame_cnt_ff + 16'h1;
      end else if (line_end) begin
        line_cnt_ff   <= line_cnt_ff + 12'h1;
      end
    end
  end

  default clocking cb @(posedge clock); endclocking
  default disable iff (srst);

  sequence s_line_done;
    pixel_valid_window ##1 !pixel_valid_window;
  endsequence

  a_line_end_only: assert property (s_line_done |-> line_end)
    else $error("line end not taken from the valid window fall");
  a_active_check: assert property (line_end |=>
      meas_act_ff == $past(act_cnt_ff) &&
      err_ff[0] == ($past(act_bad) || ($past(err_ff[0]) && !$past(err_clr[0]))))
    else $error("active count not measured or flagged");
  a_frame_lines: assert property (frame_end |=>
      line_cnt_ff == 12'h0 && (($past(line_cnt_ff) != `PVT_ACTIVE_LINES) -> err_ff[2]))
    else $error("frame line count not checked");
  a_unpack_ten: assert property (pix_take && pix_ready && depth10 && !out_valid |=>
      out_red == {$past(pix_data[7:0]), $past(pix_data[31:30])} &&
      out_blue == {$past(pix_data[23:16]), $past(pix_data[27:26])})
    else $error("30-bit unpack wrong");
  a_unpack_eight: assert property (pix_take && pix_ready && !depth10 && !out_valid |=>
      out_green[9:2] == $past(pix_data[15:8]) && out_green[1:0] == out_green[9:8])
    else $error("24-bit unpack wrong");
  a_depth_pin: assert property (!ctrl_ff[1] |-> depth10 == depth_sel_pin)
    else $error("depth select does not follow the pin");
  a_lane_order: assert property (pixel_valid_window && $past(pixel_valid_window) |->
      lane == $past(lane) + 3'h1)
    else $error("lane order not round robin");
  a_ovf_sticky: assert property (ovf_set |=>
      err_ff[3] ##1 (err_ff[3] || $past(err_clr[3])))
    else $error("overflow flag lost");
  a_bus_okay: assert property (acc && !hwrite |=> hreadyout && !hresp && hrdata == $past(rd_mux))
    else $error("ahb read answer wrong");
endmodule // pvt_panel_rx

// >>> sim/pvt_video_src.sv
// host video source model: packer words on the pixel valid window
// assumes the bench calls send_line from its seeded main thread
`timescale 1ns/100ps
module pvt_video_src (
  // clock
  input  wire logic        clock,
  // video out
  output logic             pixel_valid_window,
  output logic [31:0]      pix_data,
  output logic             hsync,
  output logic             vsync
);
  // lines start low and stay low through reset, standing in for supply sequencing
  initial begin
    pixel_valid_window = 1'b0;
    pix_data = 32'h0;
    hsync = 1'b0;
    vsync = 1'b0;
  end
  // paced by the bench clock, no spread, blanks as the caller asks
  task automatic send_line(input int act, input int blank, input bit ten);
    for (int i = 0; i < act + blank; i++) begin
      @(posedge clock);
      pixel_valid_window <= (i < act);
      pix_data <= (i < act) ? (ten ? $urandom : $urandom & 32'h00ffffff) : 32'h0;
      hsync <= 1'($urandom); // syncs are pure noise here
      vsync <= 1'($urandom);
    end
  endtask
endmodule // pvt_video_src

// >>> sim/panel_video_timing_packer_bench.sv
// bench: random packer words, table of line timing corner cases, ahb-lite
// assumes a pvt_video_src model as the host and hready tied to hreadyout
`timescale 1ns/100ps
module panel_video_timing_packer_bench;
  logic        clock = 1'b0;
  logic        srst = 1'b1;
  logic        depth_sel_pin = 1'b1;
  logic        out_ready = 1'b1;
  logic        hsel = 1'b0;
  logic [7:0]  haddr = 8'h00;
  logic [1:0]  htrans = 2'h0;
  logic        hwrite = 1'b0;
  logic [2:0]  hsize = 3'h2;
  logic [31:0] hwdata = 32'h0;
  logic        pixel_valid_window, pix_ready, out_valid, out_sol, out_sof;
  logic        hsync, vsync, hreadyout, hresp;
  logic [31:0] pix_data, hrdata, rd;
  logic [9:0]  out_red, out_green, out_blue;
  logic [2:0]  out_lane;
  logic [34:0] exp_q[$];
  int          bad_count = 0;
  int          comparisons = 0;
  int          idx = 0;
  int          gap = 0;
  int          frames = 0;
  bit          sofp = 1'b1;
  bit          ten = 1'b1;
  bit          chk_en = 1'b1;
  int          act_t[6] = '{480, 480, 480, 479, 481, 480};
  int          blank_t[6] = '{70, 60, 120, 59, 121, 61};

  always #12.5 clock = ~clock;

  pvt_video_src u_pvt_video_src (.clock(clock), .pixel_valid_window(pixel_valid_window),
    .pix_data(pix_data), .hsync(hsync), .vsync(vsync));
  pvt_panel_rx #(.FIFO_DEPTH(4)) u_pvt_panel_rx (.clock(clock), .srst(srst),
    .pixel_valid_window(pixel_valid_window), .pix_data(pix_data), .hsync(hsync),
    .vsync(vsync), .depth_sel_pin(depth_sel_pin), .pix_ready(pix_ready),
    .out_valid(out_valid), .out_ready(out_ready), .out_red(out_red), .out_green(out_green),
    .out_blue(out_blue), .out_lane(out_lane), .out_sol(out_sol), .out_sof(out_sof),
    .hsel(hsel), .haddr(haddr), .htrans(htrans), .hwrite(hwrite), .hsize(hsize),
    .hwdata(hwdata), .hready(hreadyout), .hrdata(hrdata), .hreadyout(hreadyout),
    .hresp(hresp));

  // expected pixel: colours, lane, start of line, start of frame
  function automatic logic [34:0] unpack(logic [31:0] d, bit t, int i, bit f);
    logic [29:0] c;
    c = t ? {d[7:0], d[31:30], d[15:8], d[29:28], d[23:16], d[27:26]}
          : {d[7:0], d[7:6], d[15:8], d[15:14], d[23:16], d[23:22]};
    return {c, 3'(i % 8), i == 0, f};
  endfunction

  task automatic finish_test();
    $display("comparisons %0d errors %0d", comparisons, bad_count);
    if (bad_count == 0 && comparisons > 0) begin
      $display("Testbench passed");
    end else begin
      $display("Testbench failed");
    end
    $finish;
  endtask

  task automatic chk(input logic [34:0] got, input logic [34:0] exp);
    comparisons++;
    if (got !== exp) begin
      bad_count++;
      $display("Error at %0t: got %h expected %h", $time, got, exp);
    end
  endtask

  task automatic wait_rdy();
    int n;
    n = 0;
    do begin
      @(posedge clock);
      n++;
    end while (hreadyout !== 1'b1 && n < 50);
    if (hreadyout !== 1'b1) begin
      bad_count++;
      finish_test();
    end
  endtask

  // one single word transfer; read data taken at the data phase edge
  task automatic ahb(input bit w, input logic [7:0] a, input logic [31:0] d);
    @(posedge clock);
    hsel <= 1'b1;
    haddr <= a;
    htrans <= 2'h2;
    hwrite <= w;
    wait_rdy();
    hsel <= 1'b0;
    htrans <= 2'h0;
    hwdata <= d;
    wait_rdy();
    rd = hrdata;
  endtask

  // reference model of the stream, fed from the input pins, gated by pix_ready
  always @(posedge clock) begin
    if (srst) begin
      idx = 0;
      gap = 0;
      sofp = 1'b1;
    end else begin
      if (chk_en && out_valid === 1'b1 && out_ready) begin
        chk({out_red, out_green, out_blue, out_lane, out_sol, out_sof}, exp_q.pop_front());
      end
      if (pixel_valid_window) begin
        if (chk_en && pix_ready) exp_q.push_back(unpack(pix_data, ten, idx, sofp));
        idx++;
        gap = 0;
        sofp = 1'b0;
      end else begin
        idx = 0;
        if (gap < 600) gap++;
        if (gap == 600) sofp = 1'b1;
      end
    end
  end

  // one short frame: a corner-case line, a good line, then vblank
  task automatic run_case(input int k);
    int m;
    m = k % 4;
    depth_sel_pin <= (m == 0 || m == 3);
    ten = (m % 2 == 0);
    ahb(1'b1, 8'h00, {29'h0, m == 2, m > 1, 1'b1});
    ahb(1'b1, 8'h04, 32'hf);
    u_pvt_video_src.send_line(act_t[k], blank_t[k], ten);
    u_pvt_video_src.send_line(480, 600, ten);
    repeat (2) @(posedge clock); // frame end registers one edge after the last blank sample
    frames++;
    ahb(1'b0, 8'h04, 32'h0);
    chk(rd, {27'h0, ten, 2'b01, blank_t[k] < 60 || blank_t[k] > 120, act_t[k] != 480});
    ahb(1'b0, 8'h08, 32'h0);
    chk(rd, 32'd480);
    ahb(1'b0, 8'h0c, 32'h0);
    chk(rd, 32'(blank_t[k]));
    ahb(1'b0, 8'h10, 32'h0);
    chk(rd, 32'd2);
    ahb(1'b0, 8'h14, 32'h0);
    chk(rd, 32'(frames));
    chk(35'(exp_q.size()), 35'h0);
  endtask

  initial begin
    int n;
    void'($urandom(19631));
    repeat (10) @(posedge clock);
    srst <= 1'b0;
    ahb(1'b0, 8'h00, 32'h0);
    chk(rd, 32'h1);
    ahb(1'b0, 8'h04, 32'h0);
    chk(rd, 32'h10);
    ahb(1'b1, 8'h20, 32'hffffffff);
    ahb(1'b0, 8'h20, 32'h0);
    chk(rd, 32'h0);
    chk(35'(hresp), 35'h0);
    for (int k = 0; k < 6; k++) run_case(k);
    // video cannot stall, so a blocked drain must flag overflow
    chk_en = 1'b0;
    out_ready <= 1'b0;
    u_pvt_video_src.send_line(8, 2, 1'b1);
    chk(35'(pix_ready), 35'h0);
    ahb(1'b0, 8'h04, 32'h0);
    chk(35'(rd[3]), 35'h1);
    out_ready <= 1'b1;
    n = 0;
    while (out_valid !== 1'b0 && n < 20) begin
      @(posedge clock);
      n++;
    end
    chk(35'(out_valid), 35'h0);
    ahb(1'b1, 8'h04, 32'h8);
    ahb(1'b0, 8'h04, 32'h0);
    chk(35'(rd[3]), 35'h0);
    finish_test();
  end
endmodule // panel_video_timing_packer_bench
